//--- logic/adc_dsp_cfg_pkg.sv
/*
  Shared constants and types for the audio ADC DSP configuration bank.
  Assumes byte-wide registers at page-0 byte addresses of the control port.
*/
package adc_dsp_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [7:0] ADDR_CH8_GAIN_TRIM = 8'h62;
  localparam logic [7:0] ADDR_CH8_PHASE_TRIM = 8'h63;
  localparam logic [7:0] ADDR_FILTER_SUM_CONFIG = 8'h6b;
  localparam logic [7:0] ADDR_VOLUME_BIQUAD_CONFIG = 8'h6c;

  // Reset values
  localparam logic [7:0] RST_CH8_GAIN_TRIM = 8'h80;
  localparam logic [7:0] RST_CH8_PHASE_TRIM = 8'h00;
  localparam logic [7:0] RST_FILTER_SUM_CONFIG = 8'h01;
  localparam logic [7:0] RST_VOLUME_BIQUAD_CONFIG = 8'h40;

  // Writable bit masks; other positions read zero and are never stored
  localparam logic [7:0] MASK_CH8_GAIN_TRIM = 8'hf0;
  localparam logic [7:0] MASK_FILTER_SUM_CONFIG = 8'h3f;
  localparam logic [7:0] MASK_VOLUME_BIQUAD_CONFIG = 8'hf8;

  // Field positions
  localparam int GAIN_TRIM_LSB = 4;
  localparam int DECIM_LSB = 4;
  localparam int SUM_LSB = 2;
  localparam int HPF_LSB = 0;
  localparam int GANG_BIT = 7;
  localparam int BIQUAD_LSB = 5;
  localparam int SOFT_STEP_OFF_BIT = 4;
  localparam int GAIN_FUNC_BIT = 3;

  // Neutral trim values used when channel 8 is not a PDM source, and the volume given to inactive channels
  localparam logic [3:0] GAIN_TRIM_NEUTRAL = 4'h8;
  localparam logic [7:0] PHASE_DELAY_NONE = 8'h00;
  localparam logic [7:0] VOLUME_MUTE = 8'h00;

  typedef enum logic [1:0] {
    DECIM_LINEAR = 2'h0,
    DECIM_LOW_LAT = 2'h1,
    DECIM_ULTRA_LOW = 2'h2,
    DECIM_RSVD = 2'h3
  } decimation_e;

  typedef enum logic [1:0] {
    SUM_OFF = 2'h0,
    SUM_PAIRS = 2'h1,
    SUM_QUAD = 2'h2,
    SUM_RSVD = 2'h3
  } summation_e;

  typedef enum logic [1:0] {
    HPF_IIR_PROG = 2'h0,
    HPF_CUT_00025 = 2'h1,
    HPF_CUT_002 = 2'h2,
    HPF_CUT_008 = 2'h3
  } highpass_e;

  typedef enum logic {
    GAIN_FUNC_RANGE_ENH = 1'b0,
    GAIN_FUNC_AUTO_GAIN = 1'b1
  } gain_func_e;

  // Settings handed to the decimation, filter and volume datapath
  typedef struct packed {
    logic [3:0] ch8_gain_trim_code;
    logic [7:0] ch8_phase_delay_count;
    decimation_e decimation_response_sel;
    summation_e channel_summation_sel;
    highpass_e highpass_cutoff_sel;
    logic [1:0] biquad_count;
    logic soft_step_enable;
    gain_func_e gain_function_sel;
  } dsp_config_s;

endpackage

//--- logic/adc_dsp_channel_config_regs.sv
/*
  Configuration register slice of a multichannel audio ADC signal path:
  channel-8 PDM calibration, decimation/summation/high-pass selects, volume
  ganging, biquad count, soft-step and gain-function select, plus the small
  decode that steers volume and channel summation.
  Assumes the serial control front end delivers single-cycle byte reads and
  writes on the page-0 address, synchronous to i_clk_sys.
*/
`timescale 1ns/1ps

module adc_dsp_channel_config_regs #(
  parameter int NUM_CH = 8,
  parameter int SAMPLE_W = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [adc_dsp_cfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [adc_dsp_cfg_pkg::DATA_W-1:0] i_wdata,
  output logic [adc_dsp_cfg_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_ch8_pdm_source,
  input wire logic [NUM_CH-1:0] i_channel_active,
  input wire logic [NUM_CH-1:0][7:0] i_per_channel_volume,
  input wire logic signed [3:0][SAMPLE_W-1:0] i_ch_sample,
  output adc_dsp_cfg_pkg::dsp_config_s o_config,
  output logic [NUM_CH-1:0][7:0] o_applied_volume,
  output logic signed [SAMPLE_W-1:0] o_sum_pair_a,
  output logic signed [SAMPLE_W-1:0] o_sum_pair_b,
  output logic signed [SAMPLE_W-1:0] o_sum_quad
);
  import adc_dsp_cfg_pkg::*;

  // Refused at elaboration: decode needs one channel and a sign bit
  if (NUM_CH < 1 || SAMPLE_W < 2) begin : g_bad_params
    $error("adc_dsp_channel_config_regs: bad NUM_CH or SAMPLE_W");
  end

  logic [7:0] ch8_gain_trim;
  logic [7:0] ch8_phase_trim;
  logic [7:0] filter_sum_config;
  logic [7:0] volume_biquad_config;
  logic [7:0] next_rdata;

  function automatic logic wr_hit(input logic [7:0] a);
    return i_wr_en && (i_addr == a);
  endfunction

  // Only writable positions are stored, so reserved bits stay zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ch8_gain_trim <= RST_CH8_GAIN_TRIM;
    end else if (wr_hit(ADDR_CH8_GAIN_TRIM)) begin
      ch8_gain_trim <= i_wdata & MASK_CH8_GAIN_TRIM;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ch8_phase_trim <= RST_CH8_PHASE_TRIM;
    end else if (wr_hit(ADDR_CH8_PHASE_TRIM)) begin
      ch8_phase_trim <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      filter_sum_config <= RST_FILTER_SUM_CONFIG;
    end else if (wr_hit(ADDR_FILTER_SUM_CONFIG)) begin
      filter_sum_config <= i_wdata & MASK_FILTER_SUM_CONFIG;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      volume_biquad_config <= RST_VOLUME_BIQUAD_CONFIG;
    end else if (wr_hit(ADDR_VOLUME_BIQUAD_CONFIG)) begin
      volume_biquad_config <= i_wdata & MASK_VOLUME_BIQUAD_CONFIG;
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    next_rdata = '0;
    unique case (i_addr)
      ADDR_CH8_GAIN_TRIM: next_rdata = ch8_gain_trim;
      ADDR_CH8_PHASE_TRIM: next_rdata = ch8_phase_trim;
      ADDR_FILTER_SUM_CONFIG: next_rdata = filter_sum_config;
      ADDR_VOLUME_BIQUAD_CONFIG: next_rdata = volume_biquad_config;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd_en) begin
      o_rdata <= next_rdata;
    end
  end

  // Field decode; registered so the datapath sees one settled copy
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_config <= '{ch8_gain_trim_code: GAIN_TRIM_NEUTRAL,
                    ch8_phase_delay_count: PHASE_DELAY_NONE,
                    decimation_response_sel: DECIM_LINEAR,
                    channel_summation_sel: SUM_OFF,
                    highpass_cutoff_sel: HPF_CUT_00025,
                    biquad_count: RST_VOLUME_BIQUAD_CONFIG[BIQUAD_LSB +: 2],
                    soft_step_enable: 1'b1,
                    gain_function_sel: GAIN_FUNC_RANGE_ENH};
    end else begin
      // A non-PDM channel 8 sees neutral trims: 0 dB and no delay
      o_config.ch8_gain_trim_code <= i_ch8_pdm_source ?
        ch8_gain_trim[GAIN_TRIM_LSB +: 4] : GAIN_TRIM_NEUTRAL;
      o_config.ch8_phase_delay_count <= i_ch8_pdm_source ?
        ch8_phase_trim : PHASE_DELAY_NONE;
      o_config.decimation_response_sel <=
        decimation_e'(filter_sum_config[DECIM_LSB +: 2]);
      o_config.channel_summation_sel <=
        summation_e'(filter_sum_config[SUM_LSB +: 2]);
      o_config.highpass_cutoff_sel <=
        highpass_e'(filter_sum_config[HPF_LSB +: 2]);
      o_config.biquad_count <= volume_biquad_config[BIQUAD_LSB +: 2];
      o_config.soft_step_enable <=
        ~volume_biquad_config[SOFT_STEP_OFF_BIT];
      o_config.gain_function_sel <=
        gain_func_e'(volume_biquad_config[GAIN_FUNC_BIT]);
    end
  end

  // Ganged volume ignores whether channel 1 itself is active
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_applied_volume <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!i_channel_active[c]) begin
          o_applied_volume[c] <= VOLUME_MUTE;
        end else if (volume_biquad_config[GANG_BIT]) begin
          o_applied_volume[c] <= i_per_channel_volume[0];
        end else begin
          o_applied_volume[c] <= i_per_channel_volume[c];
        end
      end
    end
  end

  // Widened sums so averaging never overflows; an element of a packed
  // array loses its sign, so each sample is sign-extended explicitly
  logic signed [SAMPLE_W:0] pair_a_sum;
  logic signed [SAMPLE_W:0] pair_b_sum;
  logic signed [SAMPLE_W+1:0] quad_sum;
  assign pair_a_sum = (SAMPLE_W+1)'($signed(i_ch_sample[0])) +
    (SAMPLE_W+1)'($signed(i_ch_sample[1]));
  assign pair_b_sum = (SAMPLE_W+1)'($signed(i_ch_sample[2])) +
    (SAMPLE_W+1)'($signed(i_ch_sample[3]));
  assign quad_sum = (SAMPLE_W+2)'(pair_a_sum) + (SAMPLE_W+2)'(pair_b_sum);

  // Outputs not used by the current mode sit at zero; reserved code idles
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sum_pair_a <= '0;
      o_sum_pair_b <= '0;
      o_sum_quad <= '0;
    end else begin
      o_sum_pair_a <= '0;
      o_sum_pair_b <= '0;
      o_sum_quad <= '0;
      if (filter_sum_config[SUM_LSB +: 2] == SUM_PAIRS) begin
        o_sum_pair_a <= pair_a_sum[SAMPLE_W:1];
        o_sum_pair_b <= pair_b_sum[SAMPLE_W:1];
      end else if (filter_sum_config[SUM_LSB +: 2] == SUM_QUAD) begin
        o_sum_quad <= quad_sum[SAMPLE_W+1:2];
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_gain_trim_pdm;
    i_ch8_pdm_source ##1 1'b1 |->
      o_config.ch8_gain_trim_code == $past(ch8_gain_trim[7:4]);
  endproperty
  a_gain_trim_pdm: assert property (p_gain_trim_pdm)
    else $error("gain trim not passed to PDM channel 8");

  property p_trim_neutral;
    !i_ch8_pdm_source |=> o_config.ch8_gain_trim_code == GAIN_TRIM_NEUTRAL
      && o_config.ch8_phase_delay_count == PHASE_DELAY_NONE;
  endproperty
  a_trim_neutral: assert property (p_trim_neutral)
    else $error("calibration applied to non-PDM channel 8");

  property p_phase_write;
    i_wr_en && i_addr == ADDR_CH8_PHASE_TRIM && i_ch8_pdm_source
      ##1 i_ch8_pdm_source
      |=> o_config.ch8_phase_delay_count == $past(i_wdata, 2);
  endproperty
  a_phase_write: assert property (p_phase_write)
    else $error("phase delay count does not follow write");

  property p_reserved_zero;
    (filter_sum_config & ~MASK_FILTER_SUM_CONFIG) == 8'h00 &&
      (volume_biquad_config & ~MASK_VOLUME_BIQUAD_CONFIG) == 8'h00 &&
      ch8_gain_trim[3:0] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved register bits hold nonzero");

  property p_rd_back;
    !i_rst && i_rd_en && i_addr == ADDR_VOLUME_BIQUAD_CONFIG && !i_wr_en
      |=> o_rdata == volume_biquad_config;
  endproperty
  a_rd_back: assert property (p_rd_back)
    else $error("processing register read mismatch");

  property p_gang;
    // Sampled reset keeps the release edge, still a reset edge, out
    !i_rst && volume_biquad_config[GANG_BIT] && i_channel_active[NUM_CH-1]
      |=> o_applied_volume[NUM_CH-1] == $past(i_per_channel_volume[0]);
  endproperty
  a_gang: assert property (p_gang)
    else $error("ganged volume not taken from channel 1");

  property p_own_vol;
    !i_rst && !volume_biquad_config[GANG_BIT] && i_channel_active[NUM_CH-1]
      |=> o_applied_volume[NUM_CH-1] ==
        $past(i_per_channel_volume[NUM_CH-1]);
  endproperty
  a_own_vol: assert property (p_own_vol)
    else $error("channel does not use its own volume");

  property p_quad_off;
    filter_sum_config[SUM_LSB +: 2] != SUM_QUAD |=> o_sum_quad == '0;
  endproperty
  a_quad_off: assert property (p_quad_off)
    else $error("quad sum output active outside quad mode");

  property p_soft_step;
    ##1 o_config.soft_step_enable ==
      !$past(volume_biquad_config[SOFT_STEP_OFF_BIT]);
  endproperty
  a_soft_step: assert property (p_soft_step)
    else $error("soft step enable wrong polarity");

endmodule // adc_dsp_channel_config_regs

//--- tb/adc_dsp_channel_config_regs_bench.sv
/*
  Self-checking bench for the DSP configuration register slice.
  Assumes the strobe register port and the decode latencies of the design.
*/
`timescale 1ns/1ps

module adc_dsp_channel_config_regs_bench;
  import adc_dsp_cfg_pkg::*;
  logic i_clk_sys, i_rst, i_wr_en, i_rd_en, i_ch8_pdm_source;
  logic [7:0] i_addr, i_wdata, o_rdata, i_channel_active;
  logic [7:0][7:0] i_per_channel_volume, o_applied_volume;
  logic signed [3:0][23:0] i_ch_sample;
  logic signed [23:0] o_sum_pair_a, o_sum_pair_b, o_sum_quad;
  dsp_config_s o_config;
  int err_count, checks_done;
  logic [7:0] exp_vol;

  adc_dsp_channel_config_regs dut (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .i_ch8_pdm_source(i_ch8_pdm_source),
    .i_channel_active(i_channel_active),
    .i_per_channel_volume(i_per_channel_volume),
    .i_ch_sample(i_ch_sample),
    .o_config(o_config),
    .o_applied_volume(o_applied_volume),
    .o_sum_pair_a(o_sum_pair_a),
    .o_sum_pair_b(o_sum_pair_b),
    .o_sum_quad(o_sum_quad)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk_byte(input string nm, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_word(input string nm, input logic [23:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk_sys);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
  endtask

  // Read data is only settled after the edge that follows the read edge
  task automatic rd(input logic [7:0] a, exp);
    @(posedge i_clk_sys);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1;
    chk_byte($sformatf("reg %h", a), exp, o_rdata);
  endtask

  // Decode lags the register by one more edge
  task automatic settle;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    $display("CHECK FAILED run time expected finish seen hang");
    conclude();
  end

  initial begin
    err_count = 0;
    checks_done = 0;
    i_rst = 1'b1;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_ch8_pdm_source = 1'b1;
    // Channel 1 left inactive so ganging must not depend on it
    i_channel_active = 8'hfe;
    for (int c = 0; c < 8; c++)
      i_per_channel_volume[c] = 8'(16 * c + 1);
    i_ch_sample = {24'h000008, 24'h000007, -24'sd3, 24'h000064};
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    settle();
    rd(8'h62, 8'h80);
    rd(8'h63, 8'h00);
    rd(8'h6b, 8'h01);
    rd(8'h6c, 8'h40);
    rd(8'h64, 8'h00);
    chk_byte("hpf", 8'h01, 8'(o_config.highpass_cutoff_sel));
    chk_byte("biquad", 8'h02, 8'(o_config.biquad_count));
    chk_byte("soft", 8'h01, 8'(o_config.soft_step_enable));
    wr(8'h62, 8'hff);
    wr(8'h63, 8'hff);
    rd(8'h62, 8'hf0);
    rd(8'h63, 8'hff);
    chk_byte("gain", 8'h0f, 8'(o_config.ch8_gain_trim_code));
    chk_byte("phase", 8'hff, o_config.ch8_phase_delay_count);
    @(posedge i_clk_sys);
    i_ch8_pdm_source <= 1'b0;
    settle();
    chk_byte("gain", 8'h08, 8'(o_config.ch8_gain_trim_code));
    chk_byte("phase", 8'h00, o_config.ch8_phase_delay_count);
    @(posedge i_clk_sys);
    i_ch8_pdm_source <= 1'b1;
    wr(8'h62, 8'h00);
    settle();
    chk_byte("gain", 8'h00, 8'(o_config.ch8_gain_trim_code));
    // Reserved bits set, but every field code a legal one
    wr(8'h6b, 8'hd7);
    rd(8'h6b, 8'h17);
    // Decimation code 3 is reserved, so the host side never sends it
    for (int i = 0; i < 4; i++) begin
      wr(8'h6b, {2'h0, 2'(i % 3), 2'h0, 2'(i)});
      settle();
      chk_byte("decim", 8'(i % 3),
        8'(o_config.decimation_response_sel));
      chk_byte("hpf", 8'(i), 8'(o_config.highpass_cutoff_sel));
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h6b, {4'h0, 2'(i), 2'h1});
      settle();
      chk_byte("sum", 8'(i), 8'(o_config.channel_summation_sel));
      chk_word("pair_a", (i == 1) ? 24'd48 : 24'd0, o_sum_pair_a);
      chk_word("pair_b", (i == 1) ? 24'd7 : 24'd0, o_sum_pair_b);
      chk_word("quad", (i == 2) ? 24'd28 : 24'd0, o_sum_quad);
    end
    wr(8'h6c, 8'hff);
    rd(8'h6c, 8'hf8);
    for (int i = 0; i < 32; i++) begin
      wr(8'h6c, 8'(i << 3));
      settle();
      chk_byte("biquad", 8'(i[3:2]), 8'(o_config.biquad_count));
      chk_byte("soft", 8'(!i[1]), 8'(o_config.soft_step_enable));
      chk_byte("func", 8'(i[0]), 8'(o_config.gain_function_sel));
      for (int c = 0; c < 8; c++) begin
        exp_vol = (c == 0) ? 8'h00 : 8'(16 * (i[4] ? 0 : c) + 1);
        chk_byte($sformatf("vol %0d", c), exp_vol,
          o_applied_volume[c]);
      end
    end
    wr(8'h64, 8'haa);
    rd(8'h64, 8'h00);
    rd(8'h6c, 8'hf8);
    // A second reset after every register was written restores defaults
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    settle();
    rd(8'h62, 8'h80);
    rd(8'h6b, 8'h01);
    rd(8'h6c, 8'h40);
    chk_byte("biquad", 8'h02, 8'(o_config.biquad_count));
    conclude();
  end
endmodule // adc_dsp_channel_config_regs_bench
